// ===== core/uhm_pkg.sv
// constants shared by the host and modem pin logic of the serial controller
package uhm_pkg;
    // register select offsets on the three address lines
    localparam logic [2:0] UHM_OFF_IER = 3'h1;
    localparam logic [2:0] UHM_OFF_IIR = 3'h2;
    localparam logic [2:0] UHM_OFF_MCR = 3'h4;
    localparam logic [2:0] UHM_OFF_MSR = 3'h6;

    // modem_control_reg field positions
    localparam int UHM_MCR_DTR = 0;
    localparam int UHM_MCR_RTS = 1;
    localparam int UHM_MCR_USER_OUTPUT_ONE = 2;
    localparam int UHM_MCR_USER_OUTPUT_TWO = 3;
    localparam int UHM_MCR_LOOP = 4;
    localparam int UHM_MCR_W = 5;

    // modem status field positions
    localparam int UHM_MSR_DCTS = 0;
    localparam int UHM_MSR_DDSR = 1;
    localparam int UHM_MSR_DDCD = 3;
    localparam int UHM_MSR_CTS = 4;
    localparam int UHM_MSR_DSR = 5;
    localparam int UHM_MSR_DCD = 7;

    // interrupt enable field positions
    localparam int UHM_IER_RXDATA = 0;
    localparam int UHM_IER_THRE = 1;
    localparam int UHM_IER_RXERR = 2;
    localparam int UHM_IER_MODEM = 3;
    localparam int UHM_IER_W = 4;

    // interrupt identification codes, highest priority first
    localparam logic [7:0] UHM_IIR_RXERR = 8'h06;
    localparam logic [7:0] UHM_IIR_RXDATA = 8'h04;
    localparam logic [7:0] UHM_IIR_THRE = 8'h02;
    localparam logic [7:0] UHM_IIR_MODEM = 8'h00;
    localparam logic [7:0] UHM_IIR_NONE = 8'h01;

    // values after reset
    localparam logic [UHM_MCR_W-1:0] UHM_MCR_RST = 5'h00;
    localparam logic [UHM_IER_W-1:0] UHM_IER_RST = 4'h0;
    localparam logic [7:0] UHM_DATA_RST = 8'h00;

    // receive clock is sixteen times the receive baud rate
    localparam int UHM_RCLK_DIV = 16;
endpackage : uhm_pkg

// ===== core/uhm_rclk_tick.sv
// edge detector and divider for the receive 16x baud clock input
`timescale 1ns/10ps
module uhm_rclk_tick #(
    parameter int DIV = uhm_pkg::UHM_RCLK_DIV
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic rclk_in,
    output logic sample_tick,
    output logic bit_tick
);
    import uhm_pkg::*;

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic rclk_q_r;
    logic [CW-1:0] div_cnt_r;
    logic rise;

    // the receive clock must run well below clk_sys to be seen as edges
    assign rise = rclk_in & ~rclk_q_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || clear) begin
            rclk_q_r <= 1'b0;
        end else if (clk_en) begin
            rclk_q_r <= rclk_in;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || clear) begin
            div_cnt_r <= '0;
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
        end else if (clk_en) begin
            sample_tick <= rise;
            bit_tick <= rise && (div_cnt_r == LAST);
            if (rise) begin
                div_cnt_r <= (div_cnt_r == LAST) ? '0 : div_cnt_r + 1'b1;
            end
        end
    end
endmodule : uhm_rclk_tick

// ===== core/uhm_pin_logic.sv
// host bus and modem pin logic of the asynchronous serial controller
//
// Function
// - any chip select inactive means accesses are ignored, device inactive.
// - modem status bit 4 shows present clear-to-send level.
// - modem status bit 0 sets on clear-to-send change since last read.
// - clear-to-send change interrupts only if enabled and auto-CTS off.
// - auto-CTS mode uses clear-to-send to gate the transmitter.
// - modem status bit 7 shows present carrier-detect level.
// - modem status bit 3 sets on carrier-detect change since last read.
// - carrier-detect change interrupts when modem status interrupt enabled.
// - modem status bit 5 shows present data-set-ready level.
// - modem status bit 1 sets on data-set-ready change since last read.
// - data-set-ready change interrupts when modem status interrupt enabled.
// - drive disable output low except while host reads.
// - terminal-ready pin driven low while its control bit is set.
// - terminal-ready pin high on master reset, loop mode, or bit cleared.
// - interrupt high for enabled receive error, data, empty holding, modem.
// - interrupt drops once serviced or on master reset.
// - master reset clears registers and sets outputs to reset levels.
// - user outputs driven low while their control bits are set.
// - user outputs high on master reset, loop mode, or bits 2/3 cleared.
// - receiver timing taken from the 16x receive clock input.
// - eight-bit three-state data bus carries data, control and status.
// - strobe high holds selects captured at its rise; low passes them.
// - auto-RTS mode lets receive threshold drive request-to-send inactive.
`timescale 1ns/10ps
module uhm_pin_logic (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic master_reset_in,
    input wire logic chip_sel_high_a,
    input wire logic chip_sel_high_b,
    input wire logic chip_sel_low,
    input wire logic address_latch_strobe,
    input wire logic [2:0] reg_addr,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic transceiver_drive_disable,
    output logic interrupt_out,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic dcd_n,
    output logic dtr_n,
    output logic rts_n,
    output logic user_output_one,
    output logic user_output_two,
    output logic loop_mode,
    input wire logic auto_cts_en,
    input wire logic auto_rts_en,
    input wire logic rx_above_threshold,
    input wire logic rx_error,
    input wire logic rx_data_ready,
    input wire logic thr_empty,
    output logic tx_allowed,
    input wire logic receive_baud_clock_in,
    output logic rx_sample_tick,
    output logic rx_bit_tick
);
    import uhm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addr_hit(input logic [2:0] addr, input logic [2:0] off);
        addr_hit = (addr == off);
    endfunction : addr_hit

    // build the modem status byte from levels and change bits
    function automatic logic [7:0] msr_byte(input logic cts, input logic dsr,
                                            input logic dcd, input logic [3:0] dlt);
        logic [7:0] v;
        v = 8'h00;
        v[UHM_MSR_DCTS] = dlt[0];
        v[UHM_MSR_DDSR] = dlt[1];
        v[UHM_MSR_DDCD] = dlt[3];
        v[UHM_MSR_CTS] = cts;
        v[UHM_MSR_DSR] = dsr;
        v[UHM_MSR_DCD] = dcd;
        msr_byte = v;
    endfunction : msr_byte

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic clr;
    logic [2:0] held_cs_r;
    logic [2:0] held_addr_r;
    logic strobe_q_r;
    logic [2:0] eff_cs;
    logic [2:0] eff_addr;
    logic selected;
    logic rd_q_r;
    logic rd_start;
    logic rd_access;
    logic wr_access;
    logic [UHM_MCR_W-1:0] mcr_r;
    logic [UHM_IER_W-1:0] ier_r;
    logic [3:0] delta_r;
    logic [3:0] delta_nxt;
    logic cts_act;
    logic dsr_act;
    logic dcd_act;
    logic cts_prev_r;
    logic dsr_prev_r;
    logic dcd_prev_r;
    logic modem_pend;
    logic [7:0] iir_val;
    logic [7:0] rd_val;

    // master reset and the system reset act alike; both are synchronous
    assign clr = !rst_n || master_reset_in;

    ////////////////////////////////////////////////////////////////////////////
    // address strobe latch

    // while the strobe is low the latch follows the pins; its rise freezes it
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            held_cs_r <= 3'h0;
            held_addr_r <= 3'h0;
            strobe_q_r <= 1'b0;
        end else if (clk_en) begin
            strobe_q_r <= address_latch_strobe;
            if (!address_latch_strobe) begin
                held_cs_r <= {chip_sel_low, chip_sel_high_b, chip_sel_high_a};
                held_addr_r <= reg_addr;
            end
        end
    end

    assign eff_cs = address_latch_strobe ? held_cs_r
                                         : {chip_sel_low, chip_sel_high_b, chip_sel_high_a};
    assign eff_addr = address_latch_strobe ? held_addr_r : reg_addr;

    // any select line at its inactive level leaves the device idle
    assign selected = eff_cs[0] & eff_cs[1] & ~eff_cs[2];
    assign rd_access = selected & host_rd;
    assign wr_access = selected & host_wr & ~host_rd;

    // side effects of a read happen once per access, at its first cycle
    assign rd_start = rd_access & ~rd_q_r;

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            rd_q_r <= 1'b0;
        end else if (clk_en) begin
            rd_q_r <= rd_access;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            mcr_r <= UHM_MCR_RST;
        end else if (clk_en && wr_access && addr_hit(eff_addr, UHM_OFF_MCR)) begin
            mcr_r <= data_in[UHM_MCR_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            ier_r <= UHM_IER_RST;
        end else if (clk_en && wr_access && addr_hit(eff_addr, UHM_OFF_IER)) begin
            ier_r <= data_in[UHM_IER_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // modem status

    // in loop mode the status inputs follow the modem control bits
    assign cts_act = mcr_r[UHM_MCR_LOOP] ? mcr_r[UHM_MCR_RTS] : ~cts_n;
    assign dsr_act = mcr_r[UHM_MCR_LOOP] ? mcr_r[UHM_MCR_DTR] : ~dsr_n;
    assign dcd_act = mcr_r[UHM_MCR_LOOP] ? mcr_r[UHM_MCR_USER_OUTPUT_TWO] : ~dcd_n;

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            cts_prev_r <= 1'b0;
            dsr_prev_r <= 1'b0;
            dcd_prev_r <= 1'b0;
        end else if (clk_en) begin
            cts_prev_r <= cts_act;
            dsr_prev_r <= dsr_act;
            dcd_prev_r <= dcd_act;
        end
    end

    // a change seen in the very cycle of the clearing read survives it
    always_comb begin
        delta_nxt = delta_r;
        if (rd_start && addr_hit(eff_addr, UHM_OFF_MSR)) begin
            delta_nxt = 4'h0;
        end
        if (cts_act != cts_prev_r) begin
            delta_nxt[0] = 1'b1;
        end
        if (dsr_act != dsr_prev_r) begin
            delta_nxt[1] = 1'b1;
        end
        if (dcd_act != dcd_prev_r) begin
            delta_nxt[3] = 1'b1;
        end
        delta_nxt[2] = 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            delta_r <= 4'h0;
        end else if (clk_en) begin
            delta_r <= delta_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt

    // with auto-CTS on, clear-to-send toggles are flow control, not events
    assign modem_pend = ier_r[UHM_IER_MODEM] &
                        ((delta_r[0] & ~auto_cts_en) | delta_r[1] | delta_r[3]);

    always_comb begin
        if (ier_r[UHM_IER_RXERR] && rx_error) begin
            iir_val = UHM_IIR_RXERR;
        end else if (ier_r[UHM_IER_RXDATA] && rx_data_ready) begin
            iir_val = UHM_IIR_RXDATA;
        end else if (ier_r[UHM_IER_THRE] && thr_empty) begin
            iir_val = UHM_IIR_THRE;
        end else if (modem_pend) begin
            iir_val = UHM_IIR_MODEM;
        end else begin
            iir_val = UHM_IIR_NONE;
        end
    end

    // sources are levels, so the output drops once the cause is serviced
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            interrupt_out <= 1'b0;
        end else if (clk_en) begin
            interrupt_out <= (iir_val != UHM_IIR_NONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host data bus

    always_comb begin
        case (eff_addr)
            UHM_OFF_IER: rd_val = {4'h0, ier_r};
            UHM_OFF_IIR: rd_val = iir_val;
            UHM_OFF_MCR: rd_val = {3'h0, mcr_r};
            UHM_OFF_MSR: rd_val = msr_byte(cts_act, dsr_act, dcd_act, delta_r);
            default: rd_val = UHM_DATA_RST;
        endcase
    end

    // read data is caught once and held, so a long read sees a stable byte
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            data_out <= UHM_DATA_RST;
            data_oe <= 1'b0;
            transceiver_drive_disable <= 1'b0;
        end else if (clk_en) begin
            if (rd_start) begin
                data_out <= rd_val;
            end
            data_oe <= rd_access;
            transceiver_drive_disable <= rd_access;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // modem outputs

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            dtr_n <= 1'b1;
            rts_n <= 1'b1;
            user_output_one <= 1'b1;
            user_output_two <= 1'b1;
            loop_mode <= 1'b0;
        end else if (clk_en) begin
            loop_mode <= mcr_r[UHM_MCR_LOOP];
            dtr_n <= ~mcr_r[UHM_MCR_DTR] | mcr_r[UHM_MCR_LOOP];
            rts_n <= ~mcr_r[UHM_MCR_RTS] | mcr_r[UHM_MCR_LOOP]
                     | (auto_rts_en & rx_above_threshold);
            user_output_one <= ~mcr_r[UHM_MCR_USER_OUTPUT_ONE] | mcr_r[UHM_MCR_LOOP];
            user_output_two <= ~mcr_r[UHM_MCR_USER_OUTPUT_TWO] | mcr_r[UHM_MCR_LOOP];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            tx_allowed <= 1'b0;
        end else if (clk_en) begin
            tx_allowed <= ~auto_cts_en | cts_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive clock

    uhm_rclk_tick #(
        .DIV(UHM_RCLK_DIV)
    ) u_rclk (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .clear(master_reset_in),
        .rclk_in(receive_baud_clock_in),
        .sample_tick(rx_sample_tick),
        .bit_tick(rx_bit_tick)
    );
endmodule : uhm_pin_logic

// ===== verification/uhm_pin_props.sv
// concurrent checks on the pin logic ports
`timescale 1ns/10ps
module uhm_pin_props
    import uhm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic master_reset_in,
    input wire logic chip_sel_high_a,
    input wire logic chip_sel_high_b,
    input wire logic chip_sel_low,
    input wire logic address_latch_strobe,
    input wire logic [2:0] reg_addr,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] data_in,
    input wire logic data_oe,
    input wire logic transceiver_drive_disable,
    input wire logic interrupt_out,
    input wire logic cts_n,
    input wire logic dtr_n,
    input wire logic rts_n,
    input wire logic user_output_one,
    input wire logic user_output_two,
    input wire logic loop_mode,
    input wire logic auto_cts_en,
    input wire logic tx_allowed,
    input wire logic receive_baud_clock_in,
    input wire logic rx_sample_tick
);
    ////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic sel;
    logic go;
    // held selects are not modelled, so only the pass-through case is judged
    assign sel = chip_sel_high_a && chip_sel_high_b && !chip_sel_low && !address_latch_strobe;
    assign go = clk_en && !master_reset_in;
    sequence s_mcr_upd;
        go && sel && host_wr && !host_rd && reg_addr == UHM_OFF_MCR ##1 go && !host_wr;
    endsequence
    a_dtr_from_bit: assert property (
        s_mcr_upd |=> dtr_n == !($past(data_in[UHM_MCR_DTR], 2) && !$past(data_in[UHM_MCR_LOOP], 2))
    ) else $error("dtr level wrong");
    a_user_outs: assert property (
        s_mcr_upd |=> {user_output_two, user_output_one} ==
            ~({2{!$past(data_in[UHM_MCR_LOOP], 2)}} & $past(data_in[UHM_MCR_USER_OUTPUT_TWO:UHM_MCR_USER_OUTPUT_ONE], 2))
    ) else $error("user outputs wrong");
    a_loop_forces: assert property (
        s_mcr_upd ##0 $past(data_in[UHM_MCR_LOOP])
            |=> dtr_n && rts_n && user_output_one && user_output_two && loop_mode
    ) else $error("loop levels wrong");
    a_mreset_levels: assert property (
        master_reset_in |=> dtr_n && rts_n && user_output_one && user_output_two
            && !interrupt_out && !data_oe && !loop_mode
    ) else $error("master reset levels wrong");
    a_read_drives: assert property (
        go && sel && host_rd |=> data_oe && transceiver_drive_disable
    ) else $error("read not driven");
    a_idle_released: assert property (
        go && !address_latch_strobe && !(sel && host_rd) |=> !data_oe && !transceiver_drive_disable
    ) else $error("bus driven while idle");
    a_tx_gate: assert property (
        (!loop_mode && !host_wr)[*2] ##0 go |=> tx_allowed == (!$past(auto_cts_en) || !$past(cts_n))
    ) else $error("transmit gate wrong");
    a_rclk_tick: assert property (
        go && $past(rst_n) && $past(clk_en) && !$past(master_reset_in)
            && $rose(receive_baud_clock_in)
            |=> rx_sample_tick
    ) else $error("sample tick missing");
endmodule : uhm_pin_props

bind uhm_pin_logic uhm_pin_props i_uhm_pin_props (.clk_sys, .rst_n, .clk_en, .master_reset_in,
    .chip_sel_high_a, .chip_sel_high_b, .chip_sel_low, .address_latch_strobe, .reg_addr,
    .host_rd, .host_wr, .data_in, .data_oe, .transceiver_drive_disable, .interrupt_out, .cts_n,
    .dtr_n, .rts_n, .user_output_one, .user_output_two, .loop_mode, .auto_cts_en, .tx_allowed,
    .receive_baud_clock_in, .rx_sample_tick);

// ===== verification/uhm_modem_model.sv
// modem model: status lines on request, data-set-ready answers terminal-ready late
`timescale 1ns/10ps
module uhm_modem_model #(
    parameter int LAT = 2
) (
    input wire logic clk_sys,
    input wire logic dtr_n,
    input wire logic cts_req,
    input wire logic dcd_req,
    output logic cts_n,
    output logic dsr_n,
    output logic dcd_n
);
    ////////////////////////////////////////
    logic [7:0] dly_r = 8'hff;
    always @(posedge clk_sys) begin
        dly_r <= {dly_r[6:0], dtr_n};
    end
    // a slow data set: the controller must not rely on an instant answer
    assign #1 dsr_n = dly_r[LAT-1];
    assign #1 cts_n = !cts_req;
    assign #1 dcd_n = !dcd_req;
endmodule : uhm_modem_model

// ===== verification/tb_top.sv
// self-checking bench for the pin logic with a modem model
`timescale 1ns/10ps
module tb_top;
    import uhm_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, master_reset_in = 1'b0, clk_en = 1'b1;
    logic chip_sel_high_a = 1'b1, chip_sel_high_b = 1'b1, chip_sel_low = 1'b0;
    logic address_latch_strobe = 1'b0, host_rd = 1'b0, host_wr = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] data_in = 8'h00, data_out;
    logic auto_cts_en = 1'b0, auto_rts_en = 1'b0, rx_above_threshold = 1'b0;
    logic rx_error = 1'b0, rx_data_ready = 1'b0, thr_empty = 1'b0;
    logic receive_baud_clock_in = 1'b0, cts_req = 1'b0, dcd_req = 1'b0;
    logic data_oe, transceiver_drive_disable, interrupt_out, cts_n, dsr_n, dcd_n;
    logic dtr_n, rts_n, user_output_one, user_output_two, loop_mode, tx_allowed;
    logic rx_sample_tick, rx_bit_tick;
    logic [7:0] codes [3] = '{UHM_IIR_RXERR, UHM_IIR_RXDATA, UHM_IIR_THRE};
    int mismatches = 0, total_checks = 0, n_st = 0, n_bt = 0, st0 = 0, bt0 = 0;
    uhm_pin_logic i_uhm_pin_logic (.clk_sys, .rst_n, .clk_en, .master_reset_in,
        .chip_sel_high_a, .chip_sel_high_b, .chip_sel_low, .address_latch_strobe, .reg_addr,
        .host_rd, .host_wr, .data_in, .data_out, .data_oe, .transceiver_drive_disable,
        .interrupt_out, .cts_n, .dsr_n, .dcd_n, .dtr_n, .rts_n, .user_output_one,
        .user_output_two, .loop_mode, .auto_cts_en, .auto_rts_en, .rx_above_threshold,
        .rx_error, .rx_data_ready, .thr_empty, .tx_allowed, .receive_baud_clock_in,
        .rx_sample_tick, .rx_bit_tick);
    uhm_modem_model i_uhm_modem_model (.clk_sys, .dtr_n, .cts_req, .dcd_req, .cts_n, .dsr_n,
        .dcd_n);
    ////////////////////////////////////////
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        n_st += rx_sample_tick;
        n_bt += rx_bit_tick;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        total_checks++;
        if (got !== ex) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    function automatic logic [7:0] pins();
        return {4'h0, dtr_n, rts_n, user_output_one, user_output_two};
    endfunction : pins
    task automatic irq(input logic e);
        chk("interrupt", {7'h0, e}, {7'h0, interrupt_out});
    endtask : irq
    // the write enable is dropped and a cycle passes so back-to-back writes stay distinct
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr = a;
        data_in = d;
        host_wr = 1'b1;
        cyc(1);
        host_wr = 1'b0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] ex, input logic s);
        reg_addr = a;
        host_rd = 1'b1;
        cyc(1);
        if (s) chk("read data", ex, data_out);
        chk("drive", {6'h0, s, s}, {6'h0, data_oe, transceiver_drive_disable});
        host_rd = 1'b0;
        cyc(1);
        chk("release", 8'h00, {6'h0, data_oe, transceiver_drive_disable});
    endtask : rd
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    initial begin
        cyc(3);
        rst_n = 1'b1;
        cyc(1);
        chk("pins", 8'h0f, pins());
        irq(1'b0);
        rd(UHM_OFF_MSR, 8'h00, 1'b1);
        $display("test reset done");
        wr(UHM_OFF_MCR, 8'h0d);
        chk("pins", 8'h04, pins());
        rd(UHM_OFF_MCR, 8'h0d, 1'b1);
        wr(UHM_OFF_MCR, 8'h1d);
        chk("pins", 8'h0f, pins());
        wr(UHM_OFF_MCR, 8'h09);
        chk("pins", 8'h06, pins());
        wr(UHM_OFF_MCR, 8'h00);
        chk("pins", 8'h0f, pins());
        cyc(4);
        rd(UHM_OFF_MSR, 8'h0a, 1'b1);
        $display("test modem control done");
        for (int i = 0; i < 3; i++) begin
            {chip_sel_high_a, chip_sel_high_b, chip_sel_low} = 3'b110 ^ (3'b100 >> i);
            wr(UHM_OFF_MCR, 8'h01);
            chk("pins", 8'h0f, pins());
            rd(UHM_OFF_MCR, 8'h00, 1'b0);
        end
        {chip_sel_high_a, chip_sel_high_b, chip_sel_low} = 3'b110;
        rd(UHM_OFF_MCR, 8'h00, 1'b1);
        $display("test deselect done");
        wr(UHM_OFF_IER, 8'h08);
        cts_req = 1'b1;
        cyc(4);
        irq(1'b1);
        rd(UHM_OFF_IIR, UHM_IIR_MODEM, 1'b1);
        rd(UHM_OFF_MSR, 8'h11, 1'b1);
        irq(1'b0);
        rd(UHM_OFF_MSR, 8'h10, 1'b1);
        auto_cts_en = 1'b1;
        cts_req = 1'b0;
        cyc(4);
        irq(1'b0);
        chk("tx allowed", 8'h00, {7'h0, tx_allowed});
        rd(UHM_OFF_MSR, 8'h01, 1'b1);
        cts_req = 1'b1;
        dcd_req = 1'b1;
        cyc(4);
        chk("tx allowed", 8'h01, {7'h0, tx_allowed});
        irq(1'b1);
        rd(UHM_OFF_MSR, 8'h99, 1'b1);
        wr(UHM_OFF_MCR, 8'h01);
        cyc(6);
        irq(1'b1);
        rd(UHM_OFF_MSR, 8'hb2, 1'b1);
        {auto_cts_en, cts_req, dcd_req} = 3'b000;
        wr(UHM_OFF_MCR, 8'h00);
        $display("test modem status done");
        wr(UHM_OFF_IER, 8'h07);
        for (int i = 0; i < 3; i++) begin
            {rx_error, rx_data_ready, thr_empty} = 3'b100 >> i;
            cyc(2);
            irq(1'b1);
            rd(UHM_OFF_IIR, codes[i], 1'b1);
            {rx_error, rx_data_ready, thr_empty} = 3'b000;
            cyc(2);
            irq(1'b0);
        end
        wr(UHM_OFF_IER, 8'h00);
        thr_empty = 1'b1;
        cyc(2);
        irq(1'b0);
        rd(UHM_OFF_IIR, UHM_IIR_NONE, 1'b1);
        thr_empty = 1'b0;
        $display("test interrupt causes done");
        wr(UHM_OFF_MCR, 8'h02);
        chk("pins", 8'h0b, pins());
        {auto_rts_en, rx_above_threshold} = 2'b11;
        cyc(2);
        chk("pins", 8'h0f, pins());
        {auto_rts_en, rx_above_threshold} = 2'b00;
        address_latch_strobe = 1'b1;
        chip_sel_high_a = 1'b0;
        wr(UHM_OFF_MCR, 8'h01);
        chk("pins", 8'h07, pins());
        address_latch_strobe = 1'b0;
        cyc(1);
        address_latch_strobe = 1'b1;
        chip_sel_high_a = 1'b1;
        wr(UHM_OFF_MCR, 8'h00);
        chk("pins", 8'h07, pins());
        address_latch_strobe = 1'b0;
        $display("test flow and strobe done");
        cyc(1);
        wr(UHM_OFF_MCR, 8'h0d);
        wr(UHM_OFF_IER, 8'h02);
        thr_empty = 1'b1;
        cyc(2);
        irq(1'b1);
        master_reset_in = 1'b1;
        cyc(1);
        master_reset_in = 1'b0;
        chk("pins", 8'h0f, pins());
        irq(1'b0);
        cyc(2);
        irq(1'b0);
        rd(UHM_OFF_MCR, 8'h00, 1'b1);
        thr_empty = 1'b0;
        // with the enable low a write must not reach the control register
        clk_en = 1'b0;
        wr(UHM_OFF_MCR, 8'h01);
        chk("frozen pins", 8'h0f, pins());
        clk_en = 1'b1;
        rd(UHM_OFF_MCR, 8'h00, 1'b1);
        $display("test master reset done");
        st0 = n_st;
        bt0 = n_bt;
        repeat (64) begin
            cyc(2);
            receive_baud_clock_in = !receive_baud_clock_in;
        end
        cyc(3);
        chk("sample ticks", 8'h20, 8'(n_st - st0));
        chk("bit ticks", 8'h02, 8'(n_bt - bt0));
        $display("test receive clock done");
        close_out();
    end
    initial begin
        #20000;
        mismatches++;
        close_out();
    end
endmodule : tb_top
